// ---- pkg/print_seq_regs.svh ----
// timing counts and bus codes for the print addressing sequencer
// assumes a 100 MHz ref_clk; counts derive from ns figures, the gap count from a us figure
// Operation
// - idle: hold ready and accept low
// - prepare up to 72 characters, bus idle
// - inter-block gap 17.5 to 1080 ms
// - drive attention low after preparation
// - wait 45 us after attention falls
// - release ready line, then sample both
// - both high: abort with error 69
// - both low: wait for ready rising
// - accept low, ready high: proceed
// - primary address nominally 140 us after attention
// - settle 20 us then assert data valid
// - no timeout awaiting accept high
// - data valid released 18 us later
// - default secondary 12 unless 32 requested
// - 57 us prep, then secondary handshake
// - 37 us after last byte, release attention
// - value 32 omits secondary address
`ifndef PRINT_SEQ_REGS_SVH
`define PRINT_SEQ_REGS_SVH
`define CLK_PERIOD_NS     10
`define BLOCK_CHARS       72
`define GAP_MIN_US        17500
`define RESP_NS           45000
`define PRIM_NS           140000
`define SETTLE_NS         20000
`define DAV_HOLD_NS       18000
`define SEC_PREP_NS       57000
`define ATN_END_NS        37000
`define RESP_CYC          (`RESP_NS / `CLK_PERIOD_NS)
`define PRIM_CYC          (`PRIM_NS / `CLK_PERIOD_NS)
`define SETTLE_CYC        (`SETTLE_NS / `CLK_PERIOD_NS)
`define DAV_HOLD_CYC      (`DAV_HOLD_NS / `CLK_PERIOD_NS)
`define SEC_PREP_CYC      (`SEC_PREP_NS / `CLK_PERIOD_NS)
`define ATN_END_CYC       (`ATN_END_NS / `CLK_PERIOD_NS)
`define GAP_CYC           (`GAP_MIN_US * 100)
`define SEC_DEFAULT       5'h0c
`define SEC_SUPPRESS      6'h20
`define LISTEN_GROUP      3'h1
`define SECOND_GROUP      3'h3
`define ERR_NO_LISTENER   8'h45
`endif

// ---- pkg/print_seq_pkg.sv ----
// types for the print addressing sequencer
// assumes print_seq_regs.svh supplies the numbers
package print_seq_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PREP,
		ST_RESP,
		ST_READY_WAIT,
		ST_PRIM_WAIT,
		ST_SETTLE,
		ST_NRFD_WAIT,
		ST_ACCEPT_WAIT,
		ST_DAV_HOLD,
		ST_SEC_PREP,
		ST_ATN_END,
		ST_GAP
	} seq_state_t;

	// bus lines as levels, low is asserted
	typedef struct packed {
		logic       atn_n;
		logic       dav_n;
		logic       nrfd_n;
		logic       ndac_n;
		logic [7:0] dio_n;
	} bus_drive_t;

	typedef struct packed {
		logic       start;
		logic       more_blocks;
		logic [4:0] device;
		logic [5:0] secondary;
		logic [6:0] char_count;
	} print_req_t;
endpackage

// ---- logic/print_addr_seq.sv ----
// print addressing sequencer: attention, listen address, secondary address
// assumes open-collector lines resolved outside; bus inputs are asynchronous
`include "print_seq_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module print_addr_seq
	import print_seq_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = `GAP_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire print_req_t req,
	input  wire logic       nrfd_in,
	input  wire logic       ndac_in,
	output logic            atn_oe,
	output logic            dav_oe,
	output logic            nrfd_oe,
	output logic            ndac_oe,
	output logic [7:0]      dio_out,
	output logic [7:0]      dio_oe,
	output logic            busy,
	output logic            done,
	output logic            error,
	output logic [7:0]      error_code
);
	initial begin
		if (GAP_CYCLES < 1)
			$error("GAP_CYCLES must be at least one");
	end

	localparam int CW = 32;

	// synchronisers for the two handshake inputs
	logic [1:0] nrfd_sync_reg;
	logic [1:0] ndac_sync_reg;
	always_ff @(posedge ref_clk) begin
		nrfd_sync_reg <= {nrfd_sync_reg[0], nrfd_in};
		ndac_sync_reg <= {ndac_sync_reg[0], ndac_in};
	end
	wire nrfd_hi = nrfd_sync_reg[1];
	wire ndac_hi = ndac_sync_reg[1];

	seq_state_t      state_reg, state_next;
	logic [CW-1:0]   cnt_reg, cnt_next;
	logic [CW-1:0]   since_atn_reg;
	logic            sec_pending_reg, sec_pending_next;
	logic            more_reg, more_next;
	logic [4:0]      dev_reg;
	logic [5:0]      sec_reg;
	logic [7:0]      byte_reg, byte_next;
	bus_drive_t      drv_reg, drv_next;
	logic            done_next, error_next;

	// command bytes: listen group and secondary group
	wire [7:0] listen_byte = {`LISTEN_GROUP, dev_reg};
	wire [7:0] second_byte = {`SECOND_GROUP, (sec_reg == `SEC_SUPPRESS) ? `SEC_DEFAULT : sec_reg[4:0]};
	wire       sec_wanted  = (req.secondary != `SEC_SUPPRESS);
	wire       user_sec    = (req.secondary != 6'h00) && sec_wanted;
	wire       expired     = (cnt_reg == '0);
	wire [CW-1:0] prep_cyc = CW'(req.char_count > 7'(`BLOCK_CHARS) ? `BLOCK_CHARS : req.char_count);
	wire [CW-1:0] prim_left = (since_atn_reg >= CW'(`PRIM_CYC)) ? CW'(1) : CW'(`PRIM_CYC) - since_atn_reg;

	// next state and bus drive
	always_comb begin
		state_next       = state_reg;
		cnt_next         = expired ? cnt_reg : cnt_reg - CW'(1);
		sec_pending_next = sec_pending_reg;
		more_next        = more_reg;
		byte_next        = byte_reg;
		drv_next         = drv_reg;
		done_next        = 1'b0;
		error_next       = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				drv_next = '{atn_n: 1'b1, dav_n: 1'b1, nrfd_n: 1'b0, ndac_n: 1'b0, dio_n: 8'hff};
				if (req.start) begin
					state_next       = ST_PREP;
					cnt_next         = prep_cyc;
					sec_pending_next = sec_wanted;
					more_next        = req.more_blocks;
				end
			end
			ST_PREP: if (expired) begin
				drv_next.atn_n  = 1'b0;
				drv_next.ndac_n = 1'b1;                      // talker lets listeners own accept
				state_next     = ST_RESP;
				cnt_next       = CW'(`RESP_CYC);
			end
			ST_RESP: if (expired) begin
				drv_next.nrfd_n = 1'b1;
				state_next      = ST_READY_WAIT;
				cnt_next        = CW'(2);                    // two sync stages before sampling
			end
			ST_READY_WAIT: if (expired) begin
				if (nrfd_hi && ndac_hi) begin
					error_next = 1'b1;
					drv_next   = '{atn_n: 1'b1, dav_n: 1'b1, nrfd_n: 1'b0, ndac_n: 1'b0, dio_n: 8'hff};
					state_next = ST_IDLE;
				end else if (nrfd_hi) begin
					state_next = ST_PRIM_WAIT;
					cnt_next   = prim_left;
				end
			end
			ST_PRIM_WAIT: if (expired) begin
				drv_next.dio_n = ~listen_byte;
				byte_next      = listen_byte;
				state_next     = ST_SETTLE;
				cnt_next       = CW'(`SETTLE_CYC);
			end
			ST_SETTLE: if (expired)
				state_next = ST_NRFD_WAIT;
			ST_NRFD_WAIT: if (nrfd_hi) begin
				drv_next.dav_n = 1'b0;
				state_next     = ST_ACCEPT_WAIT;
			end
			ST_ACCEPT_WAIT: if (ndac_hi) begin
				state_next = ST_DAV_HOLD;
				cnt_next   = CW'(`DAV_HOLD_CYC);
			end
			ST_DAV_HOLD: if (expired) begin
				drv_next.dav_n = 1'b1;
				if (sec_pending_reg) begin
					state_next = ST_SEC_PREP;
					cnt_next   = CW'(`SEC_PREP_CYC);
				end else begin
					state_next = ST_ATN_END;
					cnt_next   = CW'(`ATN_END_CYC);
				end
			end
			ST_SEC_PREP: if (expired) begin
				sec_pending_next = 1'b0;
				drv_next.dio_n   = ~second_byte;
				byte_next        = second_byte;
				state_next       = ST_SETTLE;
				cnt_next         = CW'(`SETTLE_CYC);
			end
			ST_ATN_END: if (expired) begin
				drv_next.atn_n = 1'b1;
				drv_next.dio_n = 8'hff;
				done_next      = 1'b1;
				if (more_reg) begin
					state_next = ST_GAP;
					cnt_next   = CW'(GAP_CYCLES);
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_GAP: if (expired)
				state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg       <= ST_IDLE;
			cnt_reg         <= '0;
			sec_pending_reg <= 1'b0;
			more_reg        <= 1'b0;
			byte_reg        <= 8'h00;
			drv_reg         <= '{atn_n: 1'b1, dav_n: 1'b1, nrfd_n: 1'b0, ndac_n: 1'b0, dio_n: 8'hff};
		end else begin
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			sec_pending_reg <= sec_pending_next;
			more_reg        <= more_next;
			byte_reg        <= byte_next;
			drv_reg         <= drv_next;
		end
	end

	// request capture and time since attention fell
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dev_reg       <= 5'h00;
			sec_reg       <= 6'h00;
			since_atn_reg <= '0;
		end else begin
			if (state_reg == ST_IDLE && req.start) begin
				dev_reg <= req.device;
				sec_reg <= user_sec ? req.secondary : 6'h20 | 6'(`SEC_DEFAULT);
			end
			if (drv_reg.atn_n)
				since_atn_reg <= '0;
			else if (since_atn_reg != '1)
				since_atn_reg <= since_atn_reg + CW'(1);
		end
	end

	// registered outputs; enable high while a line is pulled low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			atn_oe     <= 1'b0;
			dav_oe     <= 1'b0;
			nrfd_oe    <= 1'b1;
			ndac_oe    <= 1'b1;
			dio_out    <= 8'h00;
			dio_oe     <= 8'h00;
			busy       <= 1'b0;
			done       <= 1'b0;
			error      <= 1'b0;
			error_code <= 8'h00;
		end else begin
			atn_oe  <= ~drv_next.atn_n;
			dav_oe  <= ~drv_next.dav_n;
			nrfd_oe <= ~drv_next.nrfd_n;
			ndac_oe <= ~drv_next.ndac_n;
			dio_out <= 8'h00;
			dio_oe  <= ~drv_next.dio_n;
			busy    <= (state_next != ST_IDLE);
			done    <= done_next;
			error   <= error_next;
			if (error_next)
				error_code <= `ERR_NO_LISTENER;
		end
	end
endmodule
`default_nettype wire

// ---- verification/seq_chk.sv ----
// assertions on the sequencer ports: idle levels, delays, handshake order
// assumes a 100 MHz ref_clk and 2-flop synchronisers on the bus inputs
`timescale 1ns/10ps
`default_nettype none
module seq_chk (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       nrfd_in,
	input wire logic       ndac_in,
	input wire logic       atn_oe,
	input wire logic       dav_oe,
	input wire logic       nrfd_oe,
	input wire logic       ndac_oe,
	input wire logic [7:0] dio_oe,
	input wire logic       busy,
	input wire logic       error,
	input wire logic [7:0] error_code
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int unsigned atn_reg, dio_reg, acc_reg, post_reg;
	logic [7:0]  dq_reg;
	// cycles since attention, data change, accept high, last data-valid
	always_ff @(posedge ref_clk) begin
		dq_reg   <= dio_oe;
		atn_reg  <= atn_oe ? atn_reg + 1 : 0;
		dio_reg  <= (dio_oe != dq_reg) ? 0 : dio_reg + 1;
		acc_reg  <= (dav_oe && ndac_in) ? acc_reg + 1 : 0;
		post_reg <= (dav_oe || !atn_oe) ? 0 : post_reg + 1;
	end
	a_idle_lines: assert property (!busy && !$past(busy) |-> nrfd_oe && ndac_oe && !atn_oe && !dav_oe && dio_oe == 8'h00)
		else $error("idle bus levels wrong");
	a_resp_window: assert property ($fell(nrfd_oe) && atn_oe |-> atn_reg inside {[4499:4502]})
		else $error("ready released off the response window");
	a_prim_delay: assert property (dq_reg == 8'h00 && dio_oe != 8'h00 |-> atn_reg >= 13999)
		else $error("address placed too early");
	a_dav_settle: assert property ($rose(dav_oe) |-> dio_reg >= 1998)
		else $error("data valid before settling");
	a_ready_wait: assert property ($rose(dav_oe) |-> $past(nrfd_in, 3))
		else $error("data valid while ready low");
	a_accept_hold: assert property (dav_oe && !ndac_in |=> dav_oe)
		else $error("data valid dropped before accept");
	a_dav_release: assert property ($fell(dav_oe) |-> acc_reg inside {[1800:1804]})
		else $error("data valid hold wrong");
	a_abort_code: assert property (error |-> error_code == 8'h45 ##[0:2] !atn_oe)
		else $error("abort code or release wrong");
	a_atn_end: assert property ($fell(atn_oe) |-> error || $past(error) || post_reg inside {[3699:3702]})
		else $error("attention release delay wrong");
endmodule
`default_nettype wire

// ---- verification/listener_model.sv ----
// listener peripheral model: answers attention and the byte handshake
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module listener_model (
	input  wire logic       ref_clk,
	input  wire logic       present,
	input  wire logic       slow,
	input  wire logic       atn_oe,
	input  wire logic       dav_oe,
	input  wire logic [7:0] dio_oe,
	output logic            nrfd_pull,
	output logic            ndac_pull,
	output logic [7:0]      got,
	output logic            got_stb
);
	logic dav_q;
	int   hold;
	initial begin
		nrfd_pull = 1'b0;
		ndac_pull = 1'b0;
		got_stb = 1'b0;
	end
	// absent or no attention: lines released to the pull-ups
	always @(posedge ref_clk) begin
		got_stb <= 1'b0;
		dav_q   <= dav_oe;
		if (!present || !atn_oe) begin
			nrfd_pull <= 1'b0;
			ndac_pull <= 1'b0;
			hold      <= slow ? 6000 : 3;
		end else if (dav_oe) begin
			nrfd_pull <= 1'b1;
			got       <= dio_oe;
			got_stb   <= !dav_q;
			ndac_pull <= !dav_q;
		end else begin
			ndac_pull <= 1'b1;
			nrfd_pull <= dav_q || hold != 0;
			hold      <= dav_q ? (slow ? 6000 : 3) : (hold != 0 ? hold - 1 : 0);
		end
	end
endmodule
`default_nettype wire

// ---- verification/test_print_addr_seq.sv ----
// bench for the print addressing sequencer with one listener model
// assumes the inter-block gap is shortened to 10 cycles
`timescale 1ns/10ps
`default_nettype none
module test_print_addr_seq
	import print_seq_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       rst, present, slow, nrfd_pull, ndac_pull, got_stb;
	logic       atn_oe, dav_oe, nrfd_oe, ndac_oe, busy, done, error;
	logic [7:0] dio_oe, dio_out, error_code, got;
	logic [9:0] notes[$];
	logic [31:0] rnd;
	print_req_t req;
	int         fail_count = 0;
	int         comparisons = 0;
	wire        nrfd_in = ~(nrfd_oe | nrfd_pull);
	wire        ndac_in = ~(ndac_oe | ndac_pull);
	initial forever #5 ref_clk = ~ref_clk;
	print_addr_seq #(.GAP_CYCLES(10)) dut_u (.ref_clk(ref_clk), .rst(rst), .req(req), .nrfd_in(nrfd_in),
		.ndac_in(ndac_in), .atn_oe(atn_oe), .dav_oe(dav_oe), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
		.dio_out(dio_out), .dio_oe(dio_oe), .busy(busy), .done(done), .error(error), .error_code(error_code));
	listener_model partner_u (.ref_clk(ref_clk), .present(present), .slow(slow), .atn_oe(atn_oe),
		.dav_oe(dav_oe), .dio_oe(dio_oe), .nrfd_pull(nrfd_pull), .ndac_pull(ndac_pull), .got(got),
		.got_stb(got_stb));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// compare one observed result with the oldest note
	task automatic chk(input logic [9:0] v);
		comparisons++;
		if (notes.size() == 0 || notes[0] !== v) begin
			fail_count++;
			$display("unexpected at %0t: result %h", $time, v);
		end
		if (notes.size() != 0)
			void'(notes.pop_front());
	endtask
	// one print request: notes the bytes, the end pulse or the abort
	task automatic run(input logic [5:0] sec, input logic more, input logic pres, input logic slw);
		int n;
		rnd = xs(rnd);
		@(posedge ref_clk);
		present <= pres;
		slow    <= slw;
		req     <= '{start: 1'b1, more_blocks: more, device: rnd[4:0], secondary: sec,
			char_count: 7'(rnd[15:8] % 8'd73)};
		if (!pres) begin
			notes.push_back({2'd2, 8'h45});
		end else begin
			notes.push_back({2'd0, 3'h1, rnd[4:0]});
			if (sec != 6'h20)
				notes.push_back({2'd0, 3'h3, (sec == 6'h00) ? 5'h0c : sec[4:0]});
			notes.push_back(10'h100);
		end
		@(posedge ref_clk);
		req.start <= 1'b0;
		n = 0;
		while (notes.size() != 0 && n < 40000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 40000) begin
			fail_count++;
			$display("unexpected at %0t: no result", $time);
			conclude();
		end
		repeat (20) @(posedge ref_clk);
	endtask
	// watches bytes taken by the listener and the end pulses
	always @(posedge ref_clk) begin
		if (got_stb) chk({2'd0, got});
		if (done) chk(10'h100);
		if (error) chk({2'd2, error_code});
		if (!rst && dio_out !== 8'h00) begin
			fail_count++;
			$display("unexpected at %0t: data lines driven high", $time);
		end
	end
	initial begin
		rst = 1'b1;
		req = '0;
		present = 1'b1;
		slow = 1'b0;
		rnd = 32'hc0c9;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		run(6'h00, 1'b0, 1'b1, 1'b1);
		run(6'h20, 1'b1, 1'b1, 1'b0);
		run(6'h00, 1'b0, 1'b0, 1'b0);
		conclude();
	end
endmodule
bind print_addr_seq seq_chk chk_u (.ref_clk(ref_clk), .rst(rst), .nrfd_in(nrfd_in), .ndac_in(ndac_in),
	.atn_oe(atn_oe), .dav_oe(dav_oe), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .dio_oe(dio_oe),
	.busy(busy), .error(error), .error_code(error_code));
`default_nettype wire
